// ===== core/trmss_consts.vh
// Offsets, field positions, reset values and timing counts of the register group.
`ifndef TRMSS_CONSTS_VH
`define TRMSS_CONSTS_VH
`define TRMSS_OFF_REF_CTRL      8'h03
`define TRMSS_OFF_DELTA_LO      8'h04
`define TRMSS_OFF_DELTA_HI      8'h05
`define TRMSS_OFF_SPREAD_CTRL   8'h06
`define TRMSS_BIT_LOSS_RB       7
`define TRMSS_BIT_FREEZE        6
`define TRMSS_BIT_CLEAR         5
`define TRMSS_BIT_SIGN          7
`define TRMSS_BIT_PIN_RB_HI     5
`define TRMSS_BIT_PIN_RB_LO     4
`define TRMSS_BIT_PLL_SRC       3
`define TRMSS_BIT_PIN_OVR       2
`define TRMSS_BIT_SEL_HI        1
`define TRMSS_BIT_SEL_LO        0
`define TRMSS_RST_FREEZE        1'h0
`define TRMSS_RST_CLEAR         1'h0
`define TRMSS_RST_PLL_SRC       1'h0
`define TRMSS_RST_PIN_OVR       1'h0
`define TRMSS_RST_DELTA         16'h0000
`define TRMSS_SPREAD_OFF        2'h0
`define TRMSS_SPREAD_03         2'h1
`define TRMSS_SPREAD_RSVD       2'h2
`define TRMSS_SPREAD_05         2'h3
`define TRMSS_DELTA_STEP_PPB    763
`define TRMSS_REF_HZ            25000000
`define TRMSS_CLK_HZ            250000000
`define TRMSS_WIN_NS            1310720
`define TRMSS_WIN_CYC           ((`TRMSS_WIN_NS / 4))
`define TRMSS_NOMINAL_EDGES     32'h00008000
`define TRMSS_STRAP_WAIT        2'h2
`endif

// ===== core/trmss_freq_cmp.v
// Frequency comparison counter producing the signed reference delta.
`timescale 1ns/1ps
`include "trmss_consts.vh"
module trmss_freq_cmp
#(
    parameter WIN_CYC = `TRMSS_WIN_CYC,
    parameter NOMINAL = `TRMSS_NOMINAL_EDGES
)
(
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Synchronised reference level.
    input  wire        ref_lvl_i,
    // Result.
    output reg  [15:0] delta_o,
    output reg         delta_vld_o
);
    reg  [31:0] win_q;
    reg  [31:0] edges_q;
    reg         ref_prev_q;
    wire        rise = ref_lvl_i & ~ref_prev_q;
    wire [31:0] total = edges_q + {31'h00000000, rise};
    wire [31:0] diff  = total - NOMINAL;

    // Counts reference rising edges over a fixed window and reports the
    // difference from the nominal count; one count is one delta step.
    // An edge in the closing cycle still counts toward its own window.
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            win_q       <= 32'h00000000;
            edges_q     <= 32'h00000000;
            ref_prev_q  <= 1'h0;
            delta_o     <= `TRMSS_RST_DELTA;
            delta_vld_o <= 1'h0;
        end
        else
        begin
            ref_prev_q  <= ref_lvl_i;
            delta_vld_o <= 1'h0;
            if (win_q >= WIN_CYC - 1)
            begin
                win_q       <= 32'h00000000;
                edges_q     <= 32'h00000000;
                delta_o     <= diff[15:0];
                delta_vld_o <= 1'h1;
            end
            else
            begin
                win_q   <= win_q + 32'h00000001;
                edges_q <= edges_q + {31'h00000000, rise};
            end
        end
    end
endmodule

// ===== core/trmss_regs.v
// Timing-reference monitor and spread-spectrum control register group.
`timescale 1ns/1ps
`include "trmss_consts.vh"
// The serial protocol engine hands over one byte access per strobe.
// A write strobe takes effect at the clock edge that samples it, so a
// read taken one cycle later already sees the new value.
// A read strobe is answered one cycle later by a one-cycle valid pulse.
// The read data stays on its port until the next read replaces it.
// Offsets outside the four mapped bytes read as zero and drop writes.
// Every pin input crosses into this clock domain through two flip-flops.
// Pin readbacks therefore trail the pin by two cycles, plus one more
// cycle until they stand on the read data port.
// The spread select takes the settled pin state once, a few cycles
// after reset release, and software may overwrite it afterwards.
// A write to the spread byte before that moment wins over the strap.
// The frequency comparison counts rising reference edges over a fixed
// window of local clock cycles and subtracts the nominal edge count.
// The default window makes one count equal to one delta step.
// A shorter window keeps the nominal edge count, so the result is offset, not scaled; it suits simulation.
// The window length is a parameter so that a test can shorten it.
// The result reaches the delta bytes as one 16-bit word, so the low
// and high byte always belong to the same window.
// Software still needs the freeze bit, because its two byte reads are
// separate transfers and a window may close between them.
// The clear bit forces the delta to zero on every cycle it is set.
// Clear wins over freeze, so a frozen zero stays zero until released.
// The clear bit does not release itself; software must write it back.
// The effective spread code follows the pin unless the override is set.
// The selectable outputs get the spread code only at their high rate;
// at the low rate they always receive the off code.
// The sync flag drops whenever the filter PLL feeds the spread PLL,
// since the outputs then need not stay aligned with one another.
// Every output of this module comes straight from a flip-flop, so the
// clock path sees no decode glitches from the register logic.
// The source and override bits reset to zero on every reset.
// The delta word is a two's complement number, so a reference that
// runs slow reads back with the sign bit set.
// Reserved bits of the mapped bytes read as zero and ignore writes.
// Read-only bits likewise ignore writes; only the control bits hold
// state that software can change.
module trmss_regs
#(
    parameter WIN_CYC = `TRMSS_WIN_CYC
)
(
    // Clock and reset.
    input  wire       REF_CLK_I,
    input  wire       RST_N_I,
    // Byte access from the serial protocol engine.
    input  wire [7:0] BYTE_ADDR_I,
    input  wire [7:0] BYTE_WDATA_I,
    input  wire       BYTE_WR_I,
    input  wire       BYTE_RD_I,
    output reg  [7:0] BYTE_RDATA_O,
    output reg        BYTE_RVLD_O,
    // Device pins.
    input  wire       REF_LOSS_INDICATOR_PIN_I,
    input  wire [1:0] SPREAD_ENABLE_PIN_I,
    input  wire       PLATFORM_TIMING_REFERENCE_I,
    input  wire       SELECTABLE_FREQ_SELECT_I,
    // Controls to the clock paths.
    output reg  [1:0] FIXED_HUNDRED_SPREAD_O,
    output reg  [1:0] SELECTABLE_OUTPUTS_SPREAD_O,
    output reg        SPREAD_PLL_SOURCE_O,
    output reg        OUTPUT_SYNC_VALID_O
);
    // Pin synchronisers, two stages each.
    reg        loss_s1_q;
    reg        loss_s2_q;
    reg  [1:0] spr_s1_q;
    reg  [1:0] spr_s2_q;
    reg        ref_s1_q;
    reg        ref_s2_q;
    reg        fsel_s1_q;
    reg        fsel_s2_q;

    // Register state. The strap counter only runs in the first cycles
    // after reset release and then rests at its final value.
    reg        freeze_q;
    reg        clear_q;
    reg        pll_src_q;
    reg        pin_ovr_q;
    reg  [1:0] spread_select_q;
    reg        strap_done_q;
    reg  [1:0] strap_cnt_q;
    reg  [15:0] freq_delta_value_q;

    wire [15:0] cmp_delta;
    wire        cmp_vld;
    wire        ref_loss_pin_readback = loss_s2_q;
    wire [1:0]  spread_pin_readback   = spr_s2_q;
    wire        freq_delta_sign = freq_delta_value_q[`TRMSS_BIT_SIGN + 8];
    reg  [1:0]  spread_eff;
    reg  [7:0]  rdata_d;

    // Write decodes, one per writable byte; the read side decodes in the
    // mux below.
    wire        wr_ref_ctrl    = BYTE_WR_I &&
                                 BYTE_ADDR_I == `TRMSS_OFF_REF_CTRL;
    wire        wr_spread_ctrl = BYTE_WR_I &&
                                 BYTE_ADDR_I == `TRMSS_OFF_SPREAD_CTRL;

    // Two flip-flops before any logic reads a pin. Only the second stage
    // is read by the logic below, so a metastable first stage never
    // reaches a decision. The reference clock goes through the same pair
    // because it is asynchronous to the local clock as well.
    always @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            loss_s1_q <= 1'h0;
            loss_s2_q <= 1'h0;
            spr_s1_q  <= 2'h0;
            spr_s2_q  <= 2'h0;
            ref_s1_q  <= 1'h0;
            ref_s2_q  <= 1'h0;
            fsel_s1_q <= 1'h0;
            fsel_s2_q <= 1'h0;
        end
        else
        begin
            loss_s1_q <= REF_LOSS_INDICATOR_PIN_I;
            loss_s2_q <= loss_s1_q;
            spr_s1_q  <= SPREAD_ENABLE_PIN_I;
            spr_s2_q  <= spr_s1_q;
            ref_s1_q  <= PLATFORM_TIMING_REFERENCE_I;
            ref_s2_q  <= ref_s1_q;
            fsel_s1_q <= SELECTABLE_FREQ_SELECT_I;
            fsel_s2_q <= fsel_s1_q;
        end
    end

    // Frequency comparison; one count of its result is one delta step.
    // The reference is sampled by the local clock, which runs ten times
    // faster, so every reference edge is seen at least once.
    trmss_freq_cmp
    #(
        .WIN_CYC (WIN_CYC)
    )
    u_cmp
    (
        .clk_i       (REF_CLK_I),
        .rst_n_i     (RST_N_I),
        .ref_lvl_i   (ref_s2_q),
        .delta_o     (cmp_delta),
        .delta_vld_o (cmp_vld)
    );

    // Writable control bits; the spread select takes the pin strap once
    // the synchroniser has settled after reset release. The strap waits
    // a fixed number of cycles rather than for a pin change, because a
    // pin held steady through reset would otherwise never be taken.
    // A write to the spread byte ends the strap window at once.
    always @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            freeze_q        <= `TRMSS_RST_FREEZE;
            clear_q         <= `TRMSS_RST_CLEAR;
            pll_src_q       <= `TRMSS_RST_PLL_SRC;
            pin_ovr_q       <= `TRMSS_RST_PIN_OVR;
            spread_select_q <= `TRMSS_SPREAD_OFF;
            strap_done_q    <= 1'h0;
            strap_cnt_q     <= 2'h0;
        end
        else
        begin
            if (!strap_done_q)
            begin
                if (strap_cnt_q == `TRMSS_STRAP_WAIT)
                begin
                    spread_select_q <= spread_pin_readback;
                    strap_done_q    <= 1'h1;
                end
                else
                    strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            if (wr_ref_ctrl)
            begin
                freeze_q <= BYTE_WDATA_I[`TRMSS_BIT_FREEZE];
                clear_q  <= BYTE_WDATA_I[`TRMSS_BIT_CLEAR];
            end
            if (wr_spread_ctrl)
            begin
                pll_src_q <= BYTE_WDATA_I[`TRMSS_BIT_PLL_SRC];
                pin_ovr_q <= BYTE_WDATA_I[`TRMSS_BIT_PIN_OVR];
                spread_select_q <=
                    BYTE_WDATA_I[`TRMSS_BIT_SEL_HI:`TRMSS_BIT_SEL_LO];
                strap_done_q <= 1'h1;
            end
        end
    end

    // Delta bytes: clear wins, freeze holds, else both bytes load at once.
    // A result that arrives while frozen is dropped, not queued, so the
    // first update after release comes from the next full window.
    // Clear is tested first so that it wins over freeze.
    always @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            freq_delta_value_q <= `TRMSS_RST_DELTA;
        else if (clear_q)
            freq_delta_value_q <= `TRMSS_RST_DELTA;
        else if (!freeze_q && cmp_vld)
            freq_delta_value_q <= cmp_delta;
    end

    // Effective spread setting: pin unless overridden by the register.
    // A reserved code passes through as it stands.
    // The override bit alone decides; the two codes are never mixed.
    always @*
    begin
        if (pin_ovr_q)
            spread_eff = spread_select_q;
        else
            spread_eff = spread_pin_readback;
    end

    // Read data mux; reserved bits and unmapped offsets read zero.
    // The mux is decoded from the live address; only the registered copy
    // taken at a read strobe reaches the port.
    always @*
    begin
        rdata_d = 8'h00;
        case (BYTE_ADDR_I)
            `TRMSS_OFF_REF_CTRL:
            begin
                rdata_d[`TRMSS_BIT_LOSS_RB] = ref_loss_pin_readback;
                rdata_d[`TRMSS_BIT_FREEZE]  = freeze_q;
                rdata_d[`TRMSS_BIT_CLEAR]   = clear_q;
            end
            `TRMSS_OFF_DELTA_LO:
                rdata_d = freq_delta_value_q[7:0];
            `TRMSS_OFF_DELTA_HI:
                rdata_d = {freq_delta_sign, freq_delta_value_q[14:8]};
            `TRMSS_OFF_SPREAD_CTRL:
            begin
                rdata_d[`TRMSS_BIT_PIN_RB_HI:`TRMSS_BIT_PIN_RB_LO] =
                    spread_pin_readback;
                rdata_d[`TRMSS_BIT_PLL_SRC] = pll_src_q;
                rdata_d[`TRMSS_BIT_PIN_OVR] = pin_ovr_q;
                rdata_d[`TRMSS_BIT_SEL_HI:`TRMSS_BIT_SEL_LO] =
                    spread_select_q;
            end
            default:
                rdata_d = 8'h00;
        endcase
    end

    // Registered read answer; the data is kept until the next read so a
    // slow protocol engine can pick it up at leisure.
    always @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            BYTE_RDATA_O <= 8'h00;
            BYTE_RVLD_O  <= 1'h0;
        end
        else
        begin
            BYTE_RVLD_O <= BYTE_RD_I;
            if (BYTE_RD_I)
                BYTE_RDATA_O <= rdata_d;
        end
    end

    // Clock path controls, registered so the clock generator never sees
    // a glitch from the decode logic. The selectable outputs lose the
    // spread code whenever their frequency select asks for the low rate.
    always @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            FIXED_HUNDRED_SPREAD_O      <= `TRMSS_SPREAD_OFF;
            SELECTABLE_OUTPUTS_SPREAD_O <= `TRMSS_SPREAD_OFF;
            SPREAD_PLL_SOURCE_O         <= `TRMSS_RST_PLL_SRC;
            OUTPUT_SYNC_VALID_O         <= 1'h1;
        end
        else
        begin
            FIXED_HUNDRED_SPREAD_O <= spread_eff;
            SELECTABLE_OUTPUTS_SPREAD_O <=
                fsel_s2_q ? `TRMSS_SPREAD_OFF : spread_eff;
            SPREAD_PLL_SOURCE_O <= pll_src_q;
            OUTPUT_SYNC_VALID_O <= ~pll_src_q;
        end
    end
endmodule

// ===== testbench/trmss_regs_sva.sv
// Port-level checks for the timing-reference and spread register group.
`timescale 1ns/1ps
module trmss_regs_sva
(
    // Clock and reset.
    input wire       REF_CLK_I,
    input wire       RST_N_I,
    // Byte port.
    input wire [7:0] BYTE_ADDR_I,
    input wire       BYTE_WR_I,
    input wire       BYTE_RD_I,
    input wire [7:0] BYTE_RDATA_O,
    input wire       BYTE_RVLD_O,
    // Pins and clock-path controls.
    input wire       REF_LOSS_INDICATOR_PIN_I,
    input wire       SELECTABLE_FREQ_SELECT_I,
    input wire [1:0] SELECTABLE_OUTPUTS_SPREAD_O,
    input wire       SPREAD_PLL_SOURCE_O,
    input wire       OUTPUT_SYNC_VALID_O
);
    // Decoded requests used by several checks.
    wire rd3 = BYTE_RD_I && BYTE_ADDR_I == 8'h03;
    wire rdx = BYTE_RD_I && (BYTE_ADDR_I < 8'h03 || BYTE_ADDR_I > 8'h06);
    wire wr6 = BYTE_WR_I && BYTE_ADDR_I == 8'h06;
    wire pin = REF_LOSS_INDICATOR_PIN_I;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    chk_read_answer: assert property (BYTE_RD_I |=> BYTE_RVLD_O)
        else $error("read not answered");
    chk_no_spurious: assert property (!BYTE_RD_I |=> !BYTE_RVLD_O)
        else $error("answer without read");
    chk_rdata_hold: assert property (!BYTE_RVLD_O |-> $stable(BYTE_RDATA_O))
        else $error("read data moved without answer");
    chk_sync_source: assert property (OUTPUT_SYNC_VALID_O == !SPREAD_PLL_SOURCE_O)
        else $error("sync flag disagrees with source");
    chk_sel_off: assert property (SELECTABLE_FREQ_SELECT_I [*4] |=>
        SELECTABLE_OUTPUTS_SPREAD_O == 2'h0)
        else $error("spread on selectable outputs at low rate");
    chk_source_write: assert property ($changed(SPREAD_PLL_SOURCE_O) |->
        $past(wr6) || $past(wr6, 2))
        else $error("source changed without write");
    chk_loss_readback: assert property (rd3 && $stable(pin) &&
        $past(pin, 3) == pin |=> BYTE_RDATA_O[7] == $past(pin))
        else $error("loss readback wrong");
    chk_reserved_zero: assert property (rd3 |=> BYTE_RDATA_O[4:0] == 5'h00)
        else $error("reserved bits not zero");
    chk_unmapped_zero: assert property (rdx |=> BYTE_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind trmss_regs trmss_regs_sva i_sva
(
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .BYTE_ADDR_I(BYTE_ADDR_I),
    .BYTE_WR_I(BYTE_WR_I), .BYTE_RD_I(BYTE_RD_I),
    .BYTE_RDATA_O(BYTE_RDATA_O), .BYTE_RVLD_O(BYTE_RVLD_O),
    .REF_LOSS_INDICATOR_PIN_I(REF_LOSS_INDICATOR_PIN_I),
    .SELECTABLE_FREQ_SELECT_I(SELECTABLE_FREQ_SELECT_I),
    .SELECTABLE_OUTPUTS_SPREAD_O(SELECTABLE_OUTPUTS_SPREAD_O),
    .SPREAD_PLL_SOURCE_O(SPREAD_PLL_SOURCE_O),
    .OUTPUT_SYNC_VALID_O(OUTPUT_SYNC_VALID_O)
);

// ===== testbench/trmss_host_model.sv
// Byte-level model of the serial bus host driving the register port.
`timescale 1ns/1ps
module trmss_host_model
(
    // Clock and request from the bench.
    input  wire       clk_i,
    input  wire       go_i,
    input  wire       wr_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] data_i,
    // Byte strobes towards the register group.
    output reg  [7:0] addr_o = 8'h00,
    output reg  [7:0] wdata_o = 8'h00,
    output reg        wr_o = 1'b0,
    output reg        rd_o = 1'b0
);
    // One strobe per request; idle lines toggle so stale values never pass.
    always @(posedge clk_i)
    begin
        wr_o    <= go_i & wr_i;
        rd_o    <= go_i & ~wr_i;
        addr_o  <= go_i ? addr_i : ~addr_o;
        wdata_o <= go_i ? data_i : ~wdata_o;
    end
endmodule

// ===== testbench/tb_timing_ref_monitor_ssc_regs.sv
// Self-checking bench for the timing-reference and spread register group.
`timescale 1ns/1ps
module tb_timing_ref_monitor_ssc_regs;
    localparam WIN = 64;
    reg         clk, rst_n, go, wr, loss, pref, fsel;
    reg  [7:0]  a, d, r, rd;
    reg  [1:0]  pin;
    reg  [15:0] dl;
    wire [7:0]  addr, wdat, rdata;
    wire        bwr, brd, rvld, src, syn;
    wire [1:0]  fix, mux;
    integer     mismatches, tests_run, seed, i, ex;
    // Host model and the register group under test.
    trmss_host_model i_host (.clk_i(clk), .go_i(go), .wr_i(wr), .addr_i(a),
        .data_i(d), .addr_o(addr), .wdata_o(wdat), .wr_o(bwr), .rd_o(brd));
    trmss_regs #(.WIN_CYC(WIN)) i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .BYTE_ADDR_I(addr), .BYTE_WDATA_I(wdat), .BYTE_WR_I(bwr),
        .BYTE_RD_I(brd), .BYTE_RDATA_O(rdata), .BYTE_RVLD_O(rvld),
        .REF_LOSS_INDICATOR_PIN_I(loss), .SPREAD_ENABLE_PIN_I(pin),
        .PLATFORM_TIMING_REFERENCE_I(pref), .SELECTABLE_FREQ_SELECT_I(fsel),
        .FIXED_HUNDRED_SPREAD_O(fix), .SELECTABLE_OUTPUTS_SPREAD_O(mux),
        .SPREAD_PLL_SOURCE_O(src), .OUTPUT_SYNC_VALID_O(syn));
    // Clock, and a reference of eight clock periods, so eight edges a window.
    initial
    begin
        clk = 1'b0;
        pref = 1'b0;
        forever #2 clk = ~clk;
    end
    always #16 pref = ~pref;
    // Counts a comparison and reports any difference.
    task check(input [15:0] got, input [15:0] expv);
    begin
        tests_run = tests_run + 1;
        if (got !== expv)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, expv);
        end
    end
    endtask
    // One byte access through the host; a read waits for its answer.
    task acc(input w, input [7:0] ad, input [7:0] dt);
        integer n;
    begin
        @(negedge clk);
        go = 1'b1;
        wr = w;
        a = ad;
        d = dt;
        @(negedge clk);
        go = 1'b0;
        n = 0;
        while (!w && rvld !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1 n = n + 1;
        end
        rd = rdata;
        if (!w) check(rvld, 1'b1);
    end
    endtask
    // Writes the control byte, then reads both delta bytes.
    task delta(input [7:0] ctl, input integer wait_c, input [15:0] expv);
    begin
        acc(1'b1, 8'h03, ctl);
        repeat (wait_c) @(negedge clk);
        acc(1'b0, 8'h04, 8'h00);
        dl[7:0] = rd;
        acc(1'b0, 8'h05, 8'h00);
        dl[15:8] = rd;
        check(dl, expv);
    end
    endtask
    // Prints the counts and the verdict, then stops.
    task finish_test;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // Cuts a hung run short.
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        finish_test;
    end
    // Main sequence.
    initial
    begin
        {mismatches, tests_run, go, wr, a, d, fsel} = 0;
        seed = 64760;
        rst_n = 1'b0;
        loss = 1'b1;
        pin = 2'h3;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        acc(1'b0, 8'h06, 8'h00);
        check(rd, 8'h33);
        check({src, syn, fix}, 4'h7);
        $display("test power_up done");
        for (i = 0; i < 4; i = i + 1)
        begin
            @(negedge clk);
            loss = i[0];
            acc(1'b1, 8'h03, 8'h9F);
            acc(1'b0, 8'h03, 8'h00);
            check(rd, {i[0], 7'h00});
            acc(1'b1, 8'(i * 7), 8'hFF);
            acc(1'b0, 8'(i * 7), 8'h00);
            check(rd, 8'h00);
        end
        $display("test readback done");
        // Let a full comparison window close before the first freeze.
        repeat (WIN) @(negedge clk);
        ex = WIN / 8 - 32768;
        delta(8'h40, 150, ex[15:0]);
        acc(1'b0, 8'h03, 8'h00);
        check(rd, 8'hC0);
        check(dl[15], 1'b1);
        delta(8'h60, 0, 16'h0000);
        delta(8'h40, 150, 16'h0000);
        delta(8'h00, 150, ex[15:0]);
        delta(8'h40, 0, ex[15:0]);
        acc(1'b1, 8'h03, 8'h00);
        $display("test delta done");
        for (i = 0; i < 8; i = i + 1)
        begin
            @(negedge clk);
            r = 8'($random(seed));
            if (r[1:0] == 2'h2) r[1:0] = 2'h3;
            pin = 2'($random(seed));
            if (pin == 2'h2) pin = 2'h1;
            fsel = 1'($random(seed));
            acc(1'b1, 8'h06, r);
            acc(1'b0, 8'h06, 8'h00);
            check(rd, {2'h0, pin, r[3:0]});
            ex = r[2] ? r[1:0] : pin;
            check(fix, ex[1:0]);
            check(mux, fsel ? 2'h0 : ex[1:0]);
            check({src, syn}, {r[3], ~r[3]});
        end
        $display("test spread done");
        finish_test;
    end
endmodule
